// ==== rtl/scmc_consts.vh ====
// constants for the system clock and operating mode controller
`ifndef SCMC_CONSTS_VH
`define SCMC_CONSTS_VH
// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define SCMC_ADDR_SCC 8'h00
`define SCMC_ADDR_FOSC 8'h04
`define SCMC_ADDR_MODE 8'h08
// ****************************************************************
// field positions
// ****************************************************************
`define SCMC_CKS_HI 7
`define SCMC_CKS_LO 5
`define SCMC_FAST_KEEP_BIT 1
`define SCMC_SLOW_KEEP_BIT 0
`define SCMC_FSTABLE_BIT 1
`define SCMC_FEN_BIT 0
// ****************************************************************
// reset values and codes
// ****************************************************************
`define SCMC_CKS_RST 3'h0
`define SCMC_FAST_KEEP_RST 1'b0
`define SCMC_SLOW_KEEP_RST 1'b0
`define SCMC_FEN_RST 1'b1
`define SCMC_CKS_SLOW 3'h7
// ****************************************************************
// timing counts
// ****************************************************************
`define SCMC_FSTABLE_CYC 16'h0400
`endif

// ==== rtl/scmc_clk_switch.v ====
// glitch-free two-input clock switch with an enable
`default_nettype none
module scmc_clk_switch (
  // clock and reset of the control domain
  input wire mclk,
  input wire nrst,
  // the two candidate clock levels, already in mclk domain
  input wire clk_a,
  input wire clk_b,
  // select b instead of a, and overall enable
  input wire sel_b,
  input wire enable,
  // switched clock level
  output reg clk_out
);
  // the source actually passed through
  reg use_b_reg;
  // gate open flag
  reg open_reg;
  reg src_now;

  // ****************************************************************
  // switching logic
  // ****************************************************************
  // change source or gate only while the current output is low and
  // the new source is low too, so no high pulse is cut short
  always @* begin
    src_now = use_b_reg ? clk_b : clk_a;
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      use_b_reg <= 1'b0;
      open_reg <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      if (!clk_out && !src_now) begin
        // safe point: output low and current source low
        if (use_b_reg != sel_b) begin
          // only take the new source while it is low as well
          if (!(sel_b ? clk_b : clk_a)) begin
            use_b_reg <= sel_b;
          end
        end
        open_reg <= enable;
      end
      clk_out <= open_reg & src_now;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/scmc_top.v ====
// system clock source selection and operating mode control
//
// Implementation choices: the placing of the registers and strobed register access.
`include "scmc_consts.vh"
`default_nettype none
module scmc_top (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // oscillator raw outputs from the analog cells (asynchronous)
  input wire fast_rc_oscillator,
  input wire slow_rc_oscillator,
  // power-down instruction pulse and wake event from the core
  input wire power_down,
  input wire wake,
  // watchdog enable level from the watchdog block
  input wire wdt_enable,
  // oscillator enables to the analog cells
  output reg fast_osc_run,
  output reg slow_osc_run,
  // clocks to the consumers
  output wire system_clock,
  output reg cpu_clock,
  output reg fast_clock,
  output reg slow_clock,
  output reg watchdog_osc_clock,
  output reg timebase_clock,
  // divided fast clocks for peripherals, bit n is fast clock / 2**n
  output reg [6:0] fast_div_clock,
  // current mode, one-hot
  output reg [5:0] mode
);
  // ****************************************************************
  // operating modes
  // ****************************************************************
  localparam [5:0] M_FAST = 6'b000001;
  localparam [5:0] M_SLOW = 6'b000010;
  localparam [5:0] M_SLEEP = 6'b000100;
  localparam [5:0] M_IDLE_SLOW_ONLY = 6'b001000;
  localparam [5:0] M_IDLE_BOTH_OSC = 6'b010000;
  localparam [5:0] M_IDLE_FAST_ONLY = 6'b100000;

  // software state
  reg [2:0] clock_select_reg;
  reg fast_osc_idle_keep_reg;
  reg slow_osc_idle_keep_reg;
  reg fast_osc_enable_reg;
  reg fast_osc_stable_reg;
  reg [15:0] stable_cnt_reg;
  reg [5:0] mode_reg;
  reg [5:0] mode_next;
  // synchronisers for the oscillator levels
  reg fast_s1_reg;
  reg fast_s2_reg;
  reg slow_s1_reg;
  reg slow_s2_reg;
  // divider chain toggles on rising fast edges
  reg fast_prev_reg;
  reg [5:0] div_reg;
  // tap index applied to the system clock switch
  reg [2:0] tap_sel_reg;
  reg [6:0] taps;
  reg fast_sel_lvl;
  reg fast_on;
  reg slow_on;
  reg sys_on;
  reg sel_slow;

  // decode the low-power mode from the two keep bits
  function [5:0] scmc_halt_mode;
    input fkeep;
    input skeep;
    begin
      case ({fkeep, skeep})
        2'b00: scmc_halt_mode = M_SLEEP;
        2'b01: scmc_halt_mode = M_IDLE_SLOW_ONLY;
        2'b11: scmc_halt_mode = M_IDLE_BOTH_OSC;
        default: scmc_halt_mode = M_IDLE_FAST_ONLY;
      endcase
    end
  endfunction

  // ****************************************************************
  // oscillator synchronisers
  // ****************************************************************
  // oscillators are asynchronous; two flops before any use. the 16MHz
  // and 32kHz sources are modelled as levels sampled by mclk
  always @(posedge mclk) begin
    if (!nrst) begin
      fast_s1_reg <= 1'b0;
      fast_s2_reg <= 1'b0;
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
    end else begin
      fast_s1_reg <= fast_rc_oscillator;
      fast_s2_reg <= fast_s1_reg;
      slow_s1_reg <= slow_rc_oscillator;
      slow_s2_reg <= slow_s1_reg;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge mclk) begin
    if (!nrst) begin
      clock_select_reg <= `SCMC_CKS_RST;
      fast_osc_idle_keep_reg <= `SCMC_FAST_KEEP_RST;
      slow_osc_idle_keep_reg <= `SCMC_SLOW_KEEP_RST;
      fast_osc_enable_reg <= `SCMC_FEN_RST;
    end else if (wr) begin
      if (addr == `SCMC_ADDR_SCC) begin
        clock_select_reg <= wdata[`SCMC_CKS_HI:`SCMC_CKS_LO];
        fast_osc_idle_keep_reg <= wdata[`SCMC_FAST_KEEP_BIT];
        slow_osc_idle_keep_reg <= wdata[`SCMC_SLOW_KEEP_BIT];
      end
      if (addr == `SCMC_ADDR_FOSC) begin
        fast_osc_enable_reg <= wdata[`SCMC_FEN_BIT];
      end
    end
  end

  // ****************************************************************
  // fast oscillator stable flag
  // ****************************************************************
  // the flag drops while the oscillator is off and counts a fixed
  // settling time after it is turned on; software polls it
  always @(posedge mclk) begin
    if (!nrst) begin
      fast_osc_stable_reg <= 1'b0;
      stable_cnt_reg <= 16'h0000;
    end else if (!fast_osc_run) begin
      fast_osc_stable_reg <= 1'b0;
      stable_cnt_reg <= 16'h0000;
    end else if (stable_cnt_reg == `SCMC_FSTABLE_CYC) begin
      fast_osc_stable_reg <= 1'b1;
    end else begin
      stable_cnt_reg <= stable_cnt_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // unmapped addresses read as zero; unused bits read as zero
  always @(posedge mclk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `SCMC_ADDR_SCC: rdata <= {clock_select_reg, 3'b000,
                                  fast_osc_idle_keep_reg, slow_osc_idle_keep_reg};
        `SCMC_ADDR_FOSC: rdata <= {6'b000000, fast_osc_stable_reg, fast_osc_enable_reg};
        `SCMC_ADDR_MODE: rdata <= {2'b00, mode_reg};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  // running modes follow the select code; power-down picks a low-power
  // mode from the keep bits; wake returns to the running mode
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      M_FAST, M_SLOW: begin
        if (power_down) begin
          mode_next = scmc_halt_mode(fast_osc_idle_keep_reg,
                                     slow_osc_idle_keep_reg);
        end else if (clock_select_reg == `SCMC_CKS_SLOW) begin
          mode_next = M_SLOW;
        end else begin
          mode_next = M_FAST;
        end
      end
      M_SLEEP, M_IDLE_SLOW_ONLY, M_IDLE_BOTH_OSC, M_IDLE_FAST_ONLY: begin
        if (wake) begin
          mode_next = (clock_select_reg == `SCMC_CKS_SLOW) ? M_SLOW : M_FAST;
        end
      end
      default: mode_next = M_FAST;
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      mode_reg <= M_FAST;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // fast clock divider
  // ****************************************************************
  // a ripple-free binary counter stepped on each fast rising edge;
  // every tap is a clean 50% clock, so switching between taps at a
  // common low point is glitch free
  always @(posedge mclk) begin
    if (!nrst) begin
      fast_prev_reg <= 1'b0;
      div_reg <= 6'h00;
    end else begin
      fast_prev_reg <= fast_s2_reg;
      if (!fast_on) begin
        // a stopped oscillator leaves every tap low; a tap frozen high
        // would keep the system clock switch from ever closing or moving.
        // limitation: stopping the fast oscillator before the switch has
        // left it may cut one high phase of the system clock
        div_reg <= 6'h00;
      end else if (fast_s2_reg && !fast_prev_reg) begin
        div_reg <= div_reg + 6'h01;
      end
    end
  end

  always @* begin
    taps = {div_reg, fast_s2_reg & fast_on};
    fast_sel_lvl = taps[tap_sel_reg];
  end

  // ****************************************************************
  // divider tap selection
  // ****************************************************************
  // a new ratio is applied only while every tap is low; all taps are
  // low together just after the counter wraps, so the output keeps a
  // full low phase and no high phase is cut short
  // trade-off: a new ratio may wait up to 64 fast clock periods
  always @(posedge mclk) begin
    if (!nrst) begin
      tap_sel_reg <= `SCMC_CKS_RST;
    end else if (taps == 7'h00) begin
      tap_sel_reg <= (clock_select_reg == `SCMC_CKS_SLOW) ? 3'h0 : clock_select_reg;
    end
  end

  // ****************************************************************
  // clock gating per mode
  // ****************************************************************
  // one table: which clocks run in each mode and whether the fast oscillator runs
  always @* begin
    fast_on = 1'b0;
    slow_on = 1'b0;
    sys_on = 1'b0;
    sel_slow = (clock_select_reg == `SCMC_CKS_SLOW);
    case (mode_reg)
      M_FAST: begin
        fast_on = 1'b1;
        slow_on = 1'b1;
        sys_on = 1'b1;
      end
      M_SLOW: begin
        fast_on = fast_osc_enable_reg;
        slow_on = 1'b1;
        sys_on = 1'b1;
      end
      M_IDLE_SLOW_ONLY: begin
        slow_on = 1'b1;
        sys_on = sel_slow;
      end
      M_IDLE_BOTH_OSC: begin
        fast_on = 1'b1;
        slow_on = 1'b1;
        sys_on = 1'b1;
      end
      M_IDLE_FAST_ONLY: begin
        fast_on = 1'b1;
        sys_on = !sel_slow;
      end
      M_SLEEP: begin
        sys_on = 1'b0;
      end
      default: begin
        sys_on = 1'b0;
      end
    endcase
  end

  // registered clock and status outputs
  always @(posedge mclk) begin
    if (!nrst) begin
      fast_osc_run <= 1'b0;
      slow_osc_run <= 1'b0;
      cpu_clock <= 1'b0;
      fast_clock <= 1'b0;
      slow_clock <= 1'b0;
      watchdog_osc_clock <= 1'b0;
      timebase_clock <= 1'b0;
      fast_div_clock <= 7'h00;
      mode <= M_FAST;
    end else begin
      fast_osc_run <= fast_on;
      // the slow oscillator runs except in sleep with the watchdog off
      slow_osc_run <= !(mode_reg == M_SLEEP && !wdt_enable);
      fast_clock <= fast_on & fast_s2_reg;
      fast_div_clock <= fast_on ? taps : 7'h00;
      slow_clock <= slow_on & slow_s2_reg;
      // the watchdog runs from the slow oscillator directly; the time base is gated like the slow clock
      watchdog_osc_clock <= (mode_reg != M_SLEEP || wdt_enable) & slow_s2_reg;
      timebase_clock <= slow_on & slow_s2_reg;
      // the cpu clock is the system clock in running modes only
      cpu_clock <= (mode_reg == M_FAST || mode_reg == M_SLOW) & system_clock;
      mode <= mode_reg;
    end
  end

  // ****************************************************************
  // glitch-free system clock multiplexer
  // ****************************************************************
  // software should only leave code 111 for a fast code once the
  // stable flag is set, otherwise the switch waits on a dead clock
  scmc_clk_switch u_sys_switch (
    .mclk(mclk),
    .nrst(nrst),
    .clk_a(fast_sel_lvl),
    .clk_b(slow_s2_reg),
    .sel_b(sel_slow),
    .enable(sys_on),
    .clk_out(system_clock)
  );
endmodule
`default_nettype wire

// ==== dv/scmc_osc_model.sv ====
// behavioural model of the two rc oscillator cells feeding the controller
`default_nettype none
module scmc_osc_model #(
  parameter int SLOW_HALF = 60
) (
  // enables from the controller
  input wire logic fast_osc_run,
  input wire logic slow_osc_run,
  // raw oscillator levels back to the controller
  output logic fast_rc_oscillator,
  output logic slow_rc_oscillator
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // oscillators: run only while enabled, otherwise stand still low
  // ****************************************************************
  initial begin
    fast_rc_oscillator = 1'b0;
    slow_rc_oscillator = 1'b0;
  end
  // 16MHz fast cell, no external parts needed
  always begin
    #31.25;
    fast_rc_oscillator = fast_osc_run ? !fast_rc_oscillator : 1'b0;
  end
  // slow cell; shortened period keeps the run short
  always begin
    #(SLOW_HALF);
    slow_rc_oscillator = slow_osc_run ? !slow_rc_oscillator : 1'b0;
  end
endmodule
`default_nettype wire

// ==== dv/scmc_top_assertions.sv ====
// concurrent checks on the clock and mode controller ports
`default_nettype none
module scmc_top_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port and requests
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic power_down,
  input wire logic wdt_enable,
  // controller outputs
  input wire logic fast_osc_run,
  input wire logic system_clock,
  input wire logic cpu_clock,
  input wire logic fast_clock,
  input wire logic slow_clock,
  input wire logic watchdog_osc_clock,
  input wire logic [5:0] mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // power-down taken while the cpu runs
  sequence pd_taken;
    (mode[1:0] != 2'b00) && power_down;
  endsequence
  // a low-power mode held long enough for gating to land
  sequence lp_held;
    (mode[5:2] != 4'h0) [*8];
  endsequence
  mode_onehot_a: assert property ($onehot(mode))
    else $error("mode not one-hot");
  lp_entry_a: assert property (pd_taken |-> ##2 (mode[5:2] != 4'h0))
    else $error("power-down did not reach a low-power mode");
  cpu_stop_a: assert property (lp_held |-> !cpu_clock)
    else $error("cpu clock runs in low-power mode");
  sleep_clk_a: assert property (mode[2] [*8] |-> !(fast_clock | slow_clock | system_clock))
    else $error("clock runs in sleep");
  sleep_wdt_a: assert property ((mode[2] && !wdt_enable) [*8] |-> !watchdog_osc_clock)
    else $error("watchdog clock runs with watchdog off");
  idle_slow_only_fast_a: assert property (mode[3] [*8] |-> !fast_clock)
    else $error("fast clock runs in idle slow-only");
  idle_fast_only_slow_a: assert property (mode[5] [*8] |-> !slow_clock)
    else $error("slow clock runs in idle fast-only");
  fast_run_a: assert property ((mode[0] | mode[4] | mode[5]) [*8] |-> fast_osc_run)
    else $error("fast oscillator off where it must run");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind scmc_top scmc_top_chk u_chk (
  .mclk(mclk), .nrst(nrst), .rd(rd), .rdata(rdata), .power_down(power_down),
  .wdt_enable(wdt_enable), .fast_osc_run(fast_osc_run), .system_clock(system_clock),
  .cpu_clock(cpu_clock), .fast_clock(fast_clock), .slow_clock(slow_clock),
  .watchdog_osc_clock(watchdog_osc_clock), .mode(mode)
);
`default_nettype wire

// ==== dv/scmc_top_tb_top.sv ====
// self-checking bench for the clock and mode controller
`default_nettype none
module scmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic power_down = 1'b0, wake = 1'b0, wdt_enable = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d;
  wire [7:0] rdata;
  wire [6:0] fast_div_clock;
  wire [5:0] mode;
  wire fosc, sosc, frun, srun, system_clock, cpu_clock, fast_clock, slow_clock, wclk, tclk;
  int err_total = 0, checked = 0, cyc = 0, nf, ns, nsy, nw, nc, nt, nd;
  // low-power table: keeps, select code, watchdog, mode, {fast,slow,sys,wdt}
  localparam logic [1:0] tk [7] = '{0, 0, 1, 1, 3, 2, 2};
  localparam logic [2:0] tc [7] = '{0, 0, 0, 7, 0, 0, 7};
  localparam logic tw [7] = '{0, 1, 1, 1, 1, 1, 1};
  localparam logic [5:0] tm [7] = '{6'h04, 6'h04, 6'h08, 6'h08, 6'h10, 6'h20, 6'h20};
  localparam logic [3:0] te [7] = '{4'h0, 4'h1, 4'h5, 4'h7, 4'hf, 4'hb, 4'h9};
  scmc_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fast_rc_oscillator(fosc), .slow_rc_oscillator(sosc),
    .power_down(power_down), .wake(wake), .wdt_enable(wdt_enable), .fast_osc_run(frun),
    .slow_osc_run(srun), .system_clock(system_clock), .cpu_clock(cpu_clock),
    .fast_clock(fast_clock), .slow_clock(slow_clock), .watchdog_osc_clock(wclk),
    .timebase_clock(tclk), .fast_div_clock(fast_div_clock), .mode(mode));
  scmc_osc_model u_osc (.fast_osc_run(frun), .slow_osc_run(srun),
    .fast_rc_oscillator(fosc), .slow_rc_oscillator(sosc));
  // 100MHz clock and a cycle ceiling against hangs
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results;
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle register strobes, read data taken in the following cycle
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  task pulse(input logic w);
    @(posedge mclk);
    if (w) wake <= 1'b1;
    else power_down <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0; power_down <= 1'b0;
  endtask
  // count rising levels of each consumer clock over a window
  task win(input int w);
    logic [6:0] p, q;
    nf = 0; ns = 0; nsy = 0; nw = 0; nc = 0;
    nt = 0;
    nd = 0;
    p = {fast_clock, slow_clock, system_clock, wclk, cpu_clock, tclk, fast_div_clock[1]};
    repeat (w) begin
      @(negedge mclk);
      q = {fast_clock, slow_clock, system_clock, wclk, cpu_clock, tclk, fast_div_clock[1]};
      nf += q[6] & ~p[6]; ns += q[5] & ~p[5]; nsy += q[4] & ~p[4];
      nw += q[3] & ~p[3]; nc += q[2] & ~p[2];
      nt += q[1] & ~p[1];
      nd += q[0] & ~p[0];
      p = q;
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd_reg(8'h00, d); chk(d, 8'h00, "control reset");
    rd_reg(8'h04, d); chk(d, 8'h01, "fast osc reset");
    rd_reg(8'h08, d); chk(d, 8'h01, "mode reset");
    wr_reg(8'h0c, 8'hff); rd_reg(8'h0c, d); chk(d, 8'h00, "unmapped");
    wr_reg(8'h00, 8'hff); rd_reg(8'h00, d); chk(d, 8'he3, "control bits");
    wr_reg(8'h00, 8'h00);
    repeat (1100) @(posedge mclk);
    rd_reg(8'h04, d); chk(d, 8'h03, "stable set");
    // every fast division ratio against the fast clock
    for (int c = 0; c < 7; c++) begin
      wr_reg(8'h00, 8'(c << 5));
      // a new ratio waits for the divider to wrap, up to 400 cycles
      repeat (500) @(posedge mclk);
      win(2000);
      chk(8'(nsy >= (nf >> c) - 1 && nsy <= (nf >> c) + 1), 8'h01, "divide ratio");
      chk(8'(nc > 0 && ns > 0 && nw > 0), 8'h01, "fast mode clocks");
      chk(8'(nt > 0 && nd + 1 >= nf / 2 && nd <= nf / 2 + 1), 8'h01, "taps");
    end
    // slow mode, fast oscillator stopped and restarted
    wr_reg(8'h00, 8'he0); repeat (500) @(posedge mclk);
    rd_reg(8'h08, d); chk(d, 8'h02, "slow mode");
    win(300); chk(8'(nc > 0 && nsy >= ns - 1 && nsy <= ns + 1), 8'h01, "slow sys");
    wr_reg(8'h04, 8'h00); repeat (20) @(posedge mclk);
    win(300); chk(8'(nf > 0 || nd > 0), 8'h00, "fast stopped");
    rd_reg(8'h04, d); chk(d, 8'h00, "stable off");
    wr_reg(8'h04, 8'h01); repeat (5) @(posedge mclk);
    rd_reg(8'h04, d); chk(d, 8'h01, "stable cleared");
    repeat (1100) @(posedge mclk);
    rd_reg(8'h04, d); chk(d, 8'h03, "stable again");
    win(300); chk(8'(nf > 0 && nd > 0), 8'h01, "fast in slow");
    // every low-power mode, then wake
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h00, {tc[i], 3'b000, tk[i]});
      wdt_enable <= tw[i];
      repeat (300) @(posedge mclk);
      pulse(1'b0); repeat (40) @(posedge mclk);
      rd_reg(8'h08, d); chk(d, {2'b00, tm[i]}, "low-power mode");
      win(300);
      chk({3'b000, nf > 0, ns > 0, nsy > 0, nw > 0, nc > 0}, {3'b000, te[i], 1'b0}, "gated clocks");
      chk(8'(nt > 0), {7'h00, te[i][2]}, "timebase gated");
      pulse(1'b1); repeat (40) @(posedge mclk);
      rd_reg(8'h08, d); chk(d, (tc[i] == 3'h7) ? 8'h02 : 8'h01, "woken mode");
      if (!te[i][3]) repeat (1100) @(posedge mclk);
    end
    results;
  end
endmodule
`default_nettype wire
